// ===== shared/intctl_pkg.sv
// Purpose: Shared constants for the interrupt, context and wake controller.
// Assumes: One core clock; registers reached over a 32-bit APB slave.
// Notes: Flag and enable fields share the same bit positions.
`default_nettype none
package intctl_pkg;
    localparam logic [11:0] FLAG_GIE_OFS = 12'h000;
    localparam logic [11:0] ENABLE_WUR_OFS = 12'h004;
    localparam logic [11:0] SHADOW_BASE_OFS = 12'h008;
    localparam logic [11:0] SHADOW_LAST_OFS = 12'h014;
    localparam int ADC_BIT = 7;
    localparam int CMP_BIT = 6;
    localparam int TMR_BIT = 5;
    localparam int PIN_BIT = 4;
    localparam int GIE_BIT = 0;
    localparam int WUR_BIT = 0;
    localparam int SRC_LO = 4;
    localparam int SRC_HI = 7;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] CTX_RESET = 8'h00;
    localparam logic [10:0] VECTOR_ADDR = 11'h004;
    localparam logic [3:0] WAKE_CAPABLE_DEFAULT = 4'b0101;
    localparam int CTX_REGS = 4;
    localparam logic [1:0] CTX_WORKING = 2'h0;
    localparam logic [1:0] CTX_STATUS = 2'h1;
    localparam logic [1:0] CTX_POINTER = 2'h2;
    localparam logic [1:0] CTX_BANK = 2'h3;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_HOLD_ONE = 2'b10
    } wake_state_e;
endpackage
`default_nettype wire

// ===== design/context_bank.sv
// Purpose: Two independent sets of working, status, pointer and bank registers.
// Assumes: The core writes only the active set; software writes only the other one.
// Notes: Both views are combinational muxes of the flops, selected by isr_active.
`default_nettype none
module context_bank
    import intctl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic isr_active,
    input wire logic core_wr_en,
    input wire logic [1:0] core_wr_sel,
    input wire logic [7:0] core_wr_data,
    input wire logic sw_wr_en,
    input wire logic [1:0] sw_wr_sel,
    input wire logic [7:0] sw_wr_data,
    output logic [CTX_REGS-1:0][7:0] active_val,
    output logic [CTX_REGS-1:0][7:0] other_val
);
    logic [7:0] bank_q [2][CTX_REGS];

    // The set index follows the routine state, so a switch costs no copy.
    for (genvar s = 0; s < 2; s++) begin : g_set
        for (genvar r = 0; r < CTX_REGS; r++) begin : g_reg
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    bank_q[s][r] <= CTX_RESET;
                end else if (core_wr_en && (isr_active == 1'(s)) && core_wr_sel == 2'(r)) begin
                    bank_q[s][r] <= core_wr_data; // RQ1
                end else if (sw_wr_en && (isr_active != 1'(s)) && sw_wr_sel == 2'(r)) begin
                    bank_q[s][r] <= sw_wr_data;
                end
            end
        end
    end

    always_comb begin
        for (int r = 0; r < CTX_REGS; r++) begin
            active_val[r] = isr_active ? bank_q[1][r] : bank_q[0][r]; // RQ1
            other_val[r] = isr_active ? bank_q[0][r] : bank_q[1][r]; // RQ2
        end
    end
endmodule
`default_nettype wire

// ===== design/wake_decider.sv
// Purpose: Chooses reset, inline resume or vectoring for a wake from sleep.
// Assumes: Outputs are qualified by the caller to one wake per sleep.
// Notes: Purely combinational; the caller registers the outcome.
`default_nettype none
module wake_decider (
    input wire logic int_wake,
    input wire logic wdt_wake,
    input wire logic global_int_enable,
    input wire logic wake_reset_select,
    output logic wake_reset,
    output logic wake_inline,
    output logic wake_vector
);
    always_comb begin
        wake_reset = 1'b0;
        wake_inline = 1'b0;
        wake_vector = 1'b0;
        if (wake_reset_select && (int_wake || wdt_wake)) begin
            wake_reset = 1'b1; // RQ11
        end else if (int_wake && global_int_enable) begin
            wake_vector = 1'b1; // RQ9
        end else if (int_wake || wdt_wake) begin
            wake_inline = 1'b1; // RQ13
        end
    end
endmodule
`default_nettype wire

// ===== design/interrupt_context_wake_control.sv
// Purpose: Interrupt flags, enables, vectoring, shadow context and wake handling.
// Assumes: Events and core strobes are one-cycle pulses on pclk.
// Notes: Registers sit on APB; the core sequencer acts on the pulses it receives.
`default_nettype none
// What this block does
// RQ1: The routine uses a second working, status, pointer and bank set.
// RQ2: Four shadow registers show the set not currently in use.
// RQ3: Return pops the stack, restores the primary set and sets global enable.
// RQ4: Source flags set on events regardless of the interrupt enables.
// RQ5: Nothing vectors while global enable is clear; pending flags vector later.
// RQ6: Firmware should disable interrupts before data flash writes or erases.
// RQ7: Only sources that run without the clock may wake from sleep.
// RQ8: Firmware sets a source enable before sleeping to wake on it.
// RQ9: An interrupt wake vectors when global enable is set, else resumes inline.
// RQ10: The instruction after sleep always runs before vectoring.
// RQ11: Wake-reset set resets on wake; clear, watchdog resumes inline.
// RQ12: An accepted interrupt loads the program counter with 0x004.
// RQ13: With global enable clear a sleep interrupt only wakes, inline.
// RQ14: Flags sit in bits 7 to 4, bits 3 to 1 read zero.
// RQ15: Comparator flag responds only with a comparator wake enable set.
// RQ16: Pin flag stays inactive unless pin wake enable is set.
// RQ17: Acceptance flushes, clears enable, pushes, switches context, loads vector.
// RQ18: Every reset clears all interrupt enables.
// RQ19: Enable register holds source enables in bits 7 to 4, wake-reset bit 0.
// RQ20: A request rises with global enable and any enabled pending flag.
module interrupt_context_wake_control
    import intctl_pkg::*;
#(
    parameter logic [3:0] WAKE_CAPABLE = WAKE_CAPABLE_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic adc_done_evt,
    input wire logic cmp_one_change_evt,
    input wire logic cmp_two_change_evt,
    input wire logic timer_ovf_evt,
    input wire logic pin_change_evt,
    input wire logic comparator_one_wake_enable,
    input wire logic comparator_two_wake_enable,
    input wire logic pin_change_wake_enable,
    input wire logic instr_boundary,
    input wire logic return_from_interrupt,
    input wire logic in_sleep,
    input wire logic wdt_wake,
    input wire logic core_ctx_wr_en,
    input wire logic [1:0] core_ctx_wr_sel,
    input wire logic [7:0] core_ctx_wr_data,
    output logic [7:0] working_accumulator,
    output logic [7:0] status_reg,
    output logic [7:0] indirect_pointer_reg,
    output logic [7:0] bank_select_reg,
    output logic irq_request,
    output logic vector_take,
    output logic [10:0] vector_addr,
    output logic stack_pop,
    output logic isr_active,
    output logic wake_pulse,
    output logic wake_reset_pulse
);
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic gie_q;
    logic [3:0] src_en_q;
    logic wur_q;
    logic isr_q;
    logic wake_sent_q;
    logic wake_q;
    logic wake_reset_q;
    logic [10:0] vector_addr_q;
    logic [31:0] prdata_q;
    wake_state_e state_q;
    logic [3:0] pending;
    logic int_wake;
    logic sleep_wake;
    logic dec_reset;
    logic dec_inline;
    logic dec_vector;
    logic setup;
    logic access;
    logic wr_flag;
    logic wr_enable;
    logic wr_shadow;
    logic [3:0] src_set;
    logic [CTX_REGS-1:0][7:0] active_val;
    logic [CTX_REGS-1:0][7:0] other_val;

    function automatic logic mapped(input logic [11:0] addr);
        mapped = (addr == FLAG_GIE_OFS) || (addr == ENABLE_WUR_OFS) ||
                 (addr >= SHADOW_BASE_OFS && addr <= SHADOW_LAST_OFS && addr[1:0] == 2'b00);
    endfunction

    function automatic logic [1:0] shadow_index(input logic [11:0] addr);
        logic [11:0] rel;
        rel = addr - SHADOW_BASE_OFS;
        shadow_index = rel[3:2];
    endfunction

    // The slave never stalls, so pready is constant and errors show in pslverr only.
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = 1'b1;
    assign pslverr = access && !mapped(paddr);
    assign prdata = prdata_q;
    assign wr_flag = access && pwrite && pstrb[0] && paddr == FLAG_GIE_OFS;
    assign wr_enable = access && pwrite && pstrb[0] && paddr == ENABLE_WUR_OFS;
    assign wr_shadow = access && pwrite && pstrb[0] && mapped(paddr) && paddr >= SHADOW_BASE_OFS;

    // Source order matches flag bits 7 down to 4.
    assign src_set = {adc_done_evt, // RQ4
                      (cmp_one_change_evt && comparator_one_wake_enable) ||
                      (cmp_two_change_evt && comparator_two_wake_enable), // RQ15
                      timer_ovf_evt, // RQ4
                      pin_change_evt && pin_change_wake_enable}; // RQ16

    assign pending = flags_q[SRC_HI:SRC_LO] & src_en_q;
    assign irq_request = gie_q && (|pending); // RQ20
    // A source that stops with the clock cannot wake, even if it is flagged.
    assign int_wake = |(pending & WAKE_CAPABLE); // RQ7
    assign sleep_wake = in_sleep && !wake_sent_q && (int_wake || wdt_wake);

    // Vectoring waits for a boundary outside sleep and after the post-sleep instruction.
    assign vector_take = irq_request && instr_boundary && !in_sleep && !isr_q &&
                         state_q == ST_RUN; // RQ5 RQ10 RQ17
    assign stack_pop = return_from_interrupt && isr_q; // RQ3
    assign vector_addr = vector_addr_q;
    assign isr_active = isr_q;
    assign wake_pulse = wake_q;
    assign wake_reset_pulse = wake_reset_q;
    assign working_accumulator = active_val[CTX_WORKING];
    assign status_reg = active_val[CTX_STATUS];
    assign indirect_pointer_reg = active_val[CTX_POINTER];
    assign bank_select_reg = active_val[CTX_BANK];

    wake_decider u_wake (
        .int_wake(int_wake),
        .wdt_wake(wdt_wake),
        .global_int_enable(gie_q),
        .wake_reset_select(wur_q),
        .wake_reset(dec_reset),
        .wake_inline(dec_inline),
        .wake_vector(dec_vector)
    );

    context_bank u_ctx (
        .pclk(pclk),
        .presetn(presetn),
        .isr_active(isr_q),
        .core_wr_en(core_ctx_wr_en),
        .core_wr_sel(core_ctx_wr_sel),
        .core_wr_data(core_ctx_wr_data),
        .sw_wr_en(wr_shadow),
        .sw_wr_sel(shadow_index(paddr)),
        .sw_wr_data(pwdata[7:0]),
        .active_val(active_val),
        .other_val(other_val)
    );

    // A new event wins over a software clear in the same cycle.
    always_comb begin
        flags_d = flags_q;
        if (wr_flag) begin
            flags_d[SRC_HI:SRC_LO] = pwdata[SRC_HI:SRC_LO];
        end
        flags_d[SRC_HI:SRC_LO] = flags_d[SRC_HI:SRC_LO] | src_set; // RQ4
        flags_d[3:0] = 4'h0; // RQ14
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= FLAG_RESET;
        end else begin
            flags_q <= flags_d; // RQ14
        end
    end

    // Hardware changes to the global enable take priority over a software write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie_q <= 1'b0; // RQ18
        end else if (wake_reset_q) begin
            gie_q <= 1'b0; // RQ18
        end else if (vector_take) begin
            gie_q <= 1'b0; // RQ17
        end else if (stack_pop) begin
            gie_q <= 1'b1; // RQ3
        end else if (wr_flag) begin
            gie_q <= pwdata[GIE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_en_q <= ENABLE_RESET[SRC_HI:SRC_LO]; // RQ18
            wur_q <= ENABLE_RESET[WUR_BIT];
        end else if (wake_reset_q) begin
            src_en_q <= ENABLE_RESET[SRC_HI:SRC_LO]; // RQ18
            wur_q <= ENABLE_RESET[WUR_BIT];
        end else if (wr_enable) begin
            src_en_q <= pwdata[SRC_HI:SRC_LO]; // RQ19
            wur_q <= pwdata[WUR_BIT]; // RQ19
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            isr_q <= 1'b0;
        end else if (wake_reset_q) begin
            isr_q <= 1'b0;
        end else if (vector_take) begin
            isr_q <= 1'b1; // RQ17
        end else if (stack_pop) begin
            isr_q <= 1'b0; // RQ3
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_addr_q <= VECTOR_ADDR;
        end else begin
            vector_addr_q <= VECTOR_ADDR; // RQ12
        end
    end

    // One decision per sleep; the flag rearms when the core leaves sleep.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_sent_q <= 1'b0;
            wake_q <= 1'b0;
            wake_reset_q <= 1'b0;
        end else begin
            wake_q <= sleep_wake && (dec_inline || dec_vector); // RQ9 RQ13
            wake_reset_q <= sleep_wake && dec_reset; // RQ11
            if (!in_sleep) begin
                wake_sent_q <= 1'b0;
            end else if (sleep_wake) begin
                wake_sent_q <= 1'b1;
            end
        end
    end

    // After a wake the first boundary belongs to the instruction after sleep.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_RUN;
        end else begin
            unique case (state_q)
                ST_RUN: begin
                    if (sleep_wake && !dec_reset) begin
                        state_q <= ST_HOLD_ONE; // RQ10
                    end
                end
                ST_HOLD_ONE: begin
                    if (instr_boundary && !in_sleep) begin
                        state_q <= ST_RUN; // RQ10
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // Read data is captured in the setup phase and held through the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_q <= 32'h0000_0000;
            if (paddr == FLAG_GIE_OFS) begin
                prdata_q[7:0] <= {flags_q[SRC_HI:SRC_LO], 3'b000, gie_q}; // RQ14
            end else if (paddr == ENABLE_WUR_OFS) begin
                prdata_q[7:0] <= {src_en_q, 3'b000, wur_q}; // RQ19
            end else if (mapped(paddr)) begin
                prdata_q[7:0] <= other_val[shadow_index(paddr)]; // RQ2
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence int_wake_in_sleep_s;
        in_sleep && !wake_sent_q && int_wake && !wur_q;
    endsequence

    sequence boundary_out_of_sleep_s;
        instr_boundary && !in_sleep;
    endsequence

    vector_clears_gie_a: assert property (vector_take |=> !gie_q && isr_q) // RQ17
        else $error("Vector did not clear enable and enter routine.");
    vector_needs_gie_a: assert property (vector_take |-> gie_q && !isr_q && |pending) // RQ5
        else $error("Vector taken without enable or pending source.");
    vector_address_a: assert property (vector_take |-> vector_addr == 11'h004) // RQ12
        else $error("Vector address is not the interrupt vector.");
    return_restores_a: assert property (stack_pop && !wake_reset_q |=> gie_q && !isr_q) // RQ3
        else $error("Return did not restore enable and primary set.");
    timer_flag_set_a: assert property (timer_ovf_evt |=> flags_q[TMR_BIT]) // RQ4
        else $error("Timer flag not set by event.");
    pin_flag_gated_a: assert property (!pin_change_wake_enable && !flags_q[PIN_BIT] && !wr_flag
        |=> !flags_q[PIN_BIT]) // RQ16
        else $error("Pin flag set without pin wake enable.");
    cmp_flag_gated_a: assert property (!comparator_one_wake_enable && !comparator_two_wake_enable &&
        !flags_q[CMP_BIT] && !wr_flag |=> !flags_q[CMP_BIT]) // RQ15
        else $error("Comparator flag set without wake enable.");
    flag_low_zero_a: assert property (flags_q[3:1] == 3'b000) // RQ14
        else $error("Unused flag bits not zero.");
    request_rises_a: assert property (gie_q && |(flags_q[SRC_HI:SRC_LO] & src_en_q) |-> irq_request) // RQ20
        else $error("Enabled pending flag raised no request.");
    wake_reset_a: assert property (in_sleep && !wake_sent_q && (int_wake || wdt_wake) && wur_q
        |=> wake_reset_q && !wake_q ##1 src_en_q == 4'h0 && !gie_q) // RQ11 RQ18
        else $error("Wake with reset select did not reset enables.");
    wake_inline_a: assert property (int_wake_in_sleep_s and (!gie_q) |=> wake_q ##0 state_q == ST_HOLD_ONE) // RQ13
        else $error("Inline wake not signalled.");
    hold_one_a: assert property ((int_wake_in_sleep_s and gie_q)
        |=> state_q == ST_HOLD_ONE && !vector_take) // RQ10
        else $error("Vector before instruction after sleep.");
    hold_bound_a: assert property ((state_q == ST_HOLD_ONE) and boundary_out_of_sleep_s |=> state_q == ST_RUN) // RQ10
        else $error("Hold state did not end at boundary.");
    no_vector_in_sleep_a: assert property (in_sleep |-> !vector_take) // RQ7
        else $error("Vector taken while asleep.");
endmodule
`default_nettype wire

// ===== tb/core_partner.sv
// Purpose: Core sequencer stand-in giving instruction boundaries, sleep and wake.
// Assumes: One boundary every GAP+1 cycles while awake.
// Notes: A sleeping core has no boundaries, since the model masks them with in_sleep.
`default_nettype none
module core_partner #(
    parameter int GAP = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sleep_req,
    input wire logic vector_take,
    input wire logic wake_pulse,
    input wire logic wake_reset_pulse,
    output logic instr_boundary,
    output logic in_sleep,
    output int vectors,
    output int last_gap
);
    timeunit 1ns;
    timeprecision 1ps;
    int gap_q;
    logic [3:0] cnt_q;
    // The model never writes data flash, so it has no need to mask interrupts.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            instr_boundary <= 1'b0;
            in_sleep <= 1'b0;
            vectors <= 0;
            gap_q <= 0;
            last_gap <= 0;
        end else begin
            cnt_q <= (cnt_q == GAP) ? 4'h0 : cnt_q + 4'h1;
            instr_boundary <= !in_sleep && !sleep_req && cnt_q == GAP;
            if (sleep_req) begin
                in_sleep <= 1'b1;
            end
            if (wake_pulse || wake_reset_pulse) begin
                in_sleep <= 1'b0;
                gap_q <= 0;
            end else if (instr_boundary) begin
                gap_q <= gap_q + 1;
            end
            if (vector_take) begin
                vectors <= vectors + 1;
                last_gap <= gap_q;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb_interrupt_context_wake_control.sv
// Purpose: Self-checking bench for the interrupt, context and wake controller.
// Assumes: APB answers without wait states but the master still waits on pready.
// Notes: Event pulses are one cycle; the sleep model drives boundaries.
`default_nettype none
module tb_interrupt_context_wake_control;
    timeunit 1ns;
    timeprecision 1ps;
    import intctl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_seen;
    logic rfi, sleep_req, wdt, cwr, irq, vtake, spop, isr, wk, wkr, ib, slp;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata_q;
    logic [4:0] ev;
    logic [2:0] wen;
    logic [1:0] csel;
    logic [7:0] cdata, wacc, sreg, ptr, bank;
    logic [10:0] vaddr;
    int vectors, last_gap, fails, total_checks, cyc;

    interrupt_context_wake_control dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_done_evt(ev[4]), .cmp_one_change_evt(ev[3]),
        .cmp_two_change_evt(ev[2]), .timer_ovf_evt(ev[1]), .pin_change_evt(ev[0]),
        .comparator_one_wake_enable(wen[2]), .comparator_two_wake_enable(wen[1]),
        .pin_change_wake_enable(wen[0]), .instr_boundary(ib), .return_from_interrupt(rfi),
        .in_sleep(slp), .wdt_wake(wdt), .core_ctx_wr_en(cwr), .core_ctx_wr_sel(csel),
        .core_ctx_wr_data(cdata), .working_accumulator(wacc), .status_reg(sreg),
        .indirect_pointer_reg(ptr), .bank_select_reg(bank), .irq_request(irq), .vector_take(vtake),
        .vector_addr(vaddr), .stack_pop(spop), .isr_active(isr), .wake_pulse(wk),
        .wake_reset_pulse(wkr));

    core_partner core (
        .pclk(pclk), .presetn(presetn), .sleep_req(sleep_req), .vector_take(vtake),
        .wake_pulse(wk), .wake_reset_pulse(wkr), .instr_boundary(ib), .in_sleep(slp),
        .vectors(vectors), .last_gap(last_gap));

    always #12.5 pclk = ~pclk;

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // The request is held until pready is seen high, even though it never waits.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) fails++;
        rdata_q = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check(rdata_q, e);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic fire(input logic [4:0] m);
        @(posedge pclk);
        ev <= m;
        @(posedge pclk);
        ev <= 5'h00;
    endtask

    task automatic strobe(input int which);
        @(posedge pclk);
        if (which == 0) sleep_req <= 1'b1;
        if (which == 1) rfi <= 1'b1;
        if (which == 2) wdt <= 1'b1;
        @(negedge pclk);
        if (which == 1) check(spop, 1);
        @(posedge pclk);
        sleep_req <= 1'b0;
        rfi <= 1'b0;
        wdt <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic ctx(input logic [1:0] s, input logic [7:0] d);
        @(posedge pclk);
        cwr <= 1'b1;
        csel <= s;
        cdata <= d;
        @(posedge pclk);
        cwr <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic wait_until(input int which);
        int n;
        n = 0;
        while (n < 200 && (which == 0 ? slp === 1'b1 : vectors < which)) begin
            @(posedge pclk);
            n++;
        end
        if (n == 200) fails++;
        @(negedge pclk);
    endtask

    initial begin
        pclk = 0;
        presetn = 0;
        {psel, penable, pwrite, rfi, sleep_req, wdt, cwr} = '0;
        paddr = '0;
        pwdata = '0;
        ev = '0;
        wen = '0;
        csel = CTX_WORKING;
        cdata = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(FLAG_GIE_OFS, 32'h0000_0000);
        rd(ENABLE_WUR_OFS, 32'h0000_0000);
        rd(SHADOW_BASE_OFS, 32'h0000_0000);
        wr(ENABLE_WUR_OFS, 32'h0000_00ff);
        rd(ENABLE_WUR_OFS, 32'h0000_00f1);
        wr(ENABLE_WUR_OFS, 32'h0000_0000);
        fire(5'b10010);
        rd(FLAG_GIE_OFS, 32'h0000_00a0);
        fire(5'b01001);
        rd(FLAG_GIE_OFS, 32'h0000_00a0);
        wen <= 3'b011;
        fire(5'b00101);
        rd(FLAG_GIE_OFS, 32'h0000_00f0);
        rd(12'h018, 32'h0000_0000);
        check(err_seen, 1);
        $display("flag tests done");
        ctx(CTX_WORKING, 8'h11);
        wr(ENABLE_WUR_OFS, 32'h0000_0020);
        repeat (12) @(posedge pclk);
        check(vectors, 0);
        check(irq, 0);
        wr(FLAG_GIE_OFS, 32'h0000_00f1);
        wait_until(1);
        check(vectors, 1);
        check(vaddr, 32'h0000_0004);
        check(isr, 1);
        rd(FLAG_GIE_OFS, 32'h0000_00f0);
        ctx(CTX_WORKING, 8'h22);
        check(wacc, 32'h0000_0022);
        rd(SHADOW_BASE_OFS, 32'h0000_0011);
        ctx(CTX_BANK, 8'h33);
        check({sreg, ptr, bank}, 32'h0000_0033);
        wr(FLAG_GIE_OFS, 32'h0000_0000);
        strobe(1);
        check(isr, 0);
        check(wacc, 32'h0000_0011);
        check({sreg, ptr, bank}, 32'h0000_0000);
        rd(FLAG_GIE_OFS, 32'h0000_0001);
        rd(SHADOW_BASE_OFS, 32'h0000_0022);
        rd(SHADOW_LAST_OFS, 32'h0000_0033);
        $display("vector and context tests done");
        wr(ENABLE_WUR_OFS, 32'h0000_0010);
        strobe(0);
        fire(5'b00001);
        wait_until(2);
        check(vectors, 2);
        check(last_gap, 1);
        wr(FLAG_GIE_OFS, 32'h0000_0000);
        strobe(1);
        wr(FLAG_GIE_OFS, 32'h0000_0000);
        strobe(0);
        fire(5'b00001);
        wait_until(0);
        repeat (12) @(posedge pclk);
        check(slp, 0);
        check(vectors, 2);
        wr(FLAG_GIE_OFS, 32'h0000_0000);
        wr(ENABLE_WUR_OFS, 32'h0000_0020);
        strobe(0);
        fire(5'b00010);
        repeat (8) @(posedge pclk);
        check(slp, 1);
        strobe(2);
        wait_until(0);
        check(slp, 0);
        check(vectors, 2);
        wr(FLAG_GIE_OFS, 32'h0000_0000);
        wr(ENABLE_WUR_OFS, 32'h0000_0011);
        strobe(0);
        fire(5'b00001);
        wait_until(0);
        rd(ENABLE_WUR_OFS, 32'h0000_0000);
        rd(FLAG_GIE_OFS, 32'h0000_0010);
        $display("wake tests done");
        test_done();
    end
endmodule
`default_nettype wire
